// ===== hlc_regs.svh
`ifndef HLC_REGS_SVH
`define HLC_REGS_SVH

// counter and stack geometry
`define HLC_CNT_W        32
`define HLC_STACK_DEPTH  6

// values seen by the core
`define HLC_EMPTY_READ   32'hFFFF_FFFF
`define HLC_CNT_LAST     32'h0000_0001
`define HLC_STKY_RST     32'h0400_0000

// sticky status field positions
`define HLC_STKY_LOOP_STACK_OVERFLOW_FLAG    25
`define HLC_STKY_LOOP_STACK_EMPTY_FLAG    26

// condition latencies in machine cycles
`define HLC_LAT_NB       1
`define HLC_LAT_BR       2
`define HLC_LAT_MULT     1

`endif

// ===== hlc_pkg.sv
`include "hlc_regs.svh"

package hlc_pkg;

    // how a loop ends
    typedef enum logic [1:0] {
        KIND_COUNT   = 2'b00,
        KIND_ARITH   = 2'b01,
        KIND_FOREVER = 2'b10
    } hlc_kind_type;

    // sequencer control states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_EXIT = 2'b10
    } hlc_state_type;

    // one loop counter stack entry
    typedef struct packed {
        hlc_kind_type            kind;
        logic                    single;
        logic [`HLC_CNT_W-1:0]   count;
    } hlc_entry_type;

endpackage

// ===== hlc_delay.sv
`timescale 1ns/1ps

module hlc_delay import hlc_pkg::*; #(
    parameter int   LAT     = 1,
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // level in and delayed copy out
    input  wire logic din,
    output logic      dout
);

    logic [LAT-1:0] pipe_ff;
    logic [LAT-1:0] nxt_pipe;

    // advances every machine cycle, stalls do not hold it
    generate
        for (genvar i = 0; i < LAT; i++) begin : g_stage
            if (i == 0) begin : g_first
                always_comb nxt_pipe[i] = din;
            end else begin : g_rest
                always_comb nxt_pipe[i] = pipe_ff[i-1];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pipe_ff <= {LAT{RST_VAL}};
        end else begin
            pipe_ff <= nxt_pipe;
        end
    end

    assign dout = pipe_ff[LAT-1];

endmodule

// ===== hlc_stack.sv
`timescale 1ns/1ps
`include "hlc_regs.svh"

module hlc_stack import hlc_pkg::*; #(
    parameter int DEPTH = `HLC_STACK_DEPTH,
    parameter int WIDTH = $bits(hlc_entry_type)
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // operations, pop wins over push
    input  wire logic             push,
    input  wire logic             push_keep,
    input  wire logic             pop,
    input  wire logic             wr_top,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic [WIDTH-1:0] wr_data,
    // status
    output logic [WIDTH-1:0]      top,
    output logic                  empty,
    output logic                  full,
    output logic                  last
);

    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [CW-1:0]    cnt_ff;
    logic [CW-1:0]    nxt_cnt;

    assign empty = (cnt_ff == '0);
    assign full  = (cnt_ff == CW'(DEPTH));
    assign last  = (cnt_ff == CW'(1));
    assign top   = empty ? '0 : mem_ff[cnt_ff - 1'b1];

    // a push when full is dropped; the caller flags overflow
    always_comb begin
        nxt_mem = mem_ff;
        nxt_cnt = cnt_ff;
        if (pop) begin
            if (!empty) nxt_cnt = cnt_ff - 1'b1;
        end else if (push) begin
            if (!full) begin
                nxt_cnt = cnt_ff + 1'b1;
                if (!push_keep) nxt_mem[cnt_ff] = push_data;
            end
        end else if (wr_top && !empty) begin
            nxt_mem[cnt_ff - 1'b1] = wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // cleared so a pointer-only push never exposes unknown kinds or counts
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem_ff <= '{default: '0};
        end else begin
            mem_ff <= nxt_mem;
        end
    end

endmodule

// ===== hlc_loop_seq.sv
`timescale 1ns/1ps
`include "hlc_regs.svh"

// Overview of operation
// - top loop counter stack entry is the current loop count, read and written
// - reading the current count with an empty stack returns all ones
// - writing the current count with an empty stack changes nothing
// - writing the current count replaces the running count, no push
// - writes to the current count are ignored unless a counter loop runs
// - counter loop count comes from the init register; expiry after that many passes
// - the init register keeps its value until written again
// - current count decrements once per pass at the end-of-loop fetch
// - inverted expiry visible to branches two cycles, others one cycle later
// - latencies count machine cycles, so stalls shift the observing instruction
// - multi-instruction condition loop tests at second body fetch
// - single-instruction condition loop tests every cycle after loop start
// - true test fetches past loop end next cycle and flushes two fetch stages
// - condition loop exit aborts loop-back and pops program and loop stacks
// - endless loop repeats without any test until interrupt or reset
// - multiplier status reaches loop abort one cycle late unless stalled
// - counter stack is six by 32 bits; push when full is overflow
// - a loaded count of zero runs two to the thirty-second passes
// - sticky overflow flag sets on stack overflow, stays until cleared
// - empty flag is high while stacks are empty, cleared by a push

module hlc_loop_seq import hlc_pkg::*; #(
    parameter int DEPTH = `HLC_STACK_DEPTH
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // loop start from the pipeline
    input  wire logic                  loop_start,
    input  wire hlc_kind_type          loop_start_kind,
    input  wire logic                  loop_start_single,
    // fetch events
    input  wire logic                  end_fetch,
    input  wire logic                  second_fetch,
    // explicit stack instructions
    input  wire logic                  push_loop_instr,
    input  wire logic                  pop_loop_instr,
    // core writes
    input  wire logic                  cur_wr,
    input  wire logic [`HLC_CNT_W-1:0] cur_wr_data,
    input  wire logic                  init_wr,
    input  wire logic [`HLC_CNT_W-1:0] init_wr_data,
    // termination conditions
    input  wire logic                  arith_cond,
    input  wire logic                  mult_cond,
    input  wire logic                  stall,
    // sticky clear
    input  wire logic                  ovf_clr,
    // results
    output logic [`HLC_CNT_W-1:0]      current_loop_count_ff,
    output logic [`HLC_CNT_W-1:0]      loop_count_init_ff,
    output logic                       not_expired_br_ff,
    output logic                       not_expired_nb_ff,
    output logic                       loop_back_ff,
    output logic                       exit_fetch_ff,
    output logic                       flush_fetch_ff,
    output logic                       stack_pop_ff,
    output logic [31:0]                sticky_status_ff
);

    hlc_state_type         state_ff;
    hlc_state_type         nxt_state;
    hlc_entry_type         stk_top;
    hlc_entry_type         push_entry;
    hlc_entry_type         wr_entry;
    logic                  stk_empty;
    logic                  stk_full;
    logic                  stk_last;
    logic                  do_push;
    logic                  do_pop;
    logic                  wr_top;
    logic                  ctr_run;
    logic                  ar_test;
    logic                  ar_hit;
    logic                  ctr_end;
    logic                  term_now;
    logic                  mult_d1;
    logic                  not_lce_raw;
    logic                  not_br_d;
    logic [`HLC_CNT_W-1:0] nxt_cur;
    logic [`HLC_CNT_W-1:0] nxt_init;
    logic                  nxt_loop_back;
    logic                  nxt_exit;
    logic                  nxt_flush;
    logic                  nxt_pop;
    logic [31:0]           nxt_sticky;

    // six entries, synchronized with the loop address stack
    hlc_stack #(
        .DEPTH     (DEPTH),
        .WIDTH     ($bits(hlc_entry_type))
    ) u_stack (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .push      (do_push),
        .push_keep (!loop_start),
        .pop       (do_pop),
        .wr_top    (wr_top),
        .push_data (push_entry),
        .wr_data   (wr_entry),
        .top       (stk_top),
        .empty     (stk_empty),
        .full      (stk_full),
        .last      (stk_last)
    );

    // multiplier status arrives one machine cycle late
    hlc_delay #(
        .LAT     (`HLC_LAT_MULT),
        .RST_VAL (1'b0)
    ) u_mult_dly (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (mult_cond),
        .dout    (mult_d1)
    );

    // a stall hides the extra cycle
    assign term_now = arith_cond | (stall ? mult_cond : mult_d1);

    // expiry means the pass now running is the final one
    assign ctr_run     = !stk_empty && (stk_top.kind == KIND_COUNT);
    assign not_lce_raw = !(ctr_run && (stk_top.count == `HLC_CNT_LAST));

    // fixed machine-cycle latencies, no stall hold
    // the output register supplies one cycle, so the branch path adds only the rest
    // the non-branch copy is the output register alone
    hlc_delay #(
        .LAT     (`HLC_LAT_BR - `HLC_LAT_NB),
        .RST_VAL (1'b1)
    ) u_br_dly (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (not_lce_raw),
        .dout    (not_br_d)
    );

    // stack operations and loop decisions
    always_comb begin
        ar_test = 1'b0;
        if (state_ff == ST_RUN && !stk_empty && stk_top.kind == KIND_ARITH) begin
            ar_test = stk_top.single ? 1'b1 : second_fetch;
        end
        ar_hit  = ar_test && term_now;
        ctr_end = ctr_run && end_fetch && (stk_top.count == `HLC_CNT_LAST);
        // exits pop both stacks at once
        do_pop  = pop_loop_instr || ctr_end || ar_hit;
        do_push = !do_pop && (loop_start || push_loop_instr);
        // only a running counter loop accepts a count change
        wr_top  = !do_pop && !do_push && ctr_run && (cur_wr || end_fetch);
        wr_entry = stk_top;
        if (cur_wr) begin
            wr_entry.count = cur_wr_data;
        end else begin
            wr_entry.count = stk_top.count - 1'b1;
        end
        push_entry.kind   = loop_start_kind;
        push_entry.single = loop_start_single;
        push_entry.count  = loop_count_init_ff;
    end

    // control state and registered outputs
    always_comb begin
        nxt_state     = state_ff;
        nxt_init      = init_wr ? init_wr_data : loop_count_init_ff;
        nxt_cur       = stk_empty ? `HLC_EMPTY_READ : stk_top.count;
        // endless loops never test, they only loop back
        nxt_loop_back = end_fetch && !stk_empty && state_ff == ST_RUN
                        && !ctr_end && !ar_hit;
        nxt_exit      = ar_hit;
        nxt_flush     = ar_hit;
        nxt_pop       = do_pop && !stk_empty;
        nxt_sticky    = '0;
        // set beats clear in the same cycle
        nxt_sticky[`HLC_STKY_LOOP_STACK_OVERFLOW_FLAG] = (sticky_status_ff[`HLC_STKY_LOOP_STACK_OVERFLOW_FLAG] && !ovf_clr)
                                     || (do_push && stk_full);
        nxt_sticky[`HLC_STKY_LOOP_STACK_EMPTY_FLAG] = (stk_empty && !do_push)
                                     || (do_pop && stk_last);
        case (state_ff)
            ST_IDLE: begin
                if (do_push) nxt_state = ST_RUN;
            end
            ST_RUN: begin
                if (ar_hit) begin
                    nxt_state = ST_EXIT;
                end else if (do_pop && stk_last) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_EXIT: begin
                // flushed slots are not tested again
                nxt_state = (stk_empty && !do_push) ? ST_IDLE : ST_RUN;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff              <= ST_IDLE;
            current_loop_count_ff <= `HLC_EMPTY_READ;
            loop_count_init_ff    <= '0;
            not_expired_br_ff     <= 1'b1;
            not_expired_nb_ff     <= 1'b1;
            loop_back_ff          <= 1'b0;
            exit_fetch_ff         <= 1'b0;
            flush_fetch_ff        <= 1'b0;
            stack_pop_ff          <= 1'b0;
            sticky_status_ff      <= `HLC_STKY_RST;
        end else begin
            state_ff              <= nxt_state;
            current_loop_count_ff <= nxt_cur;
            loop_count_init_ff    <= nxt_init;
            not_expired_br_ff     <= not_br_d;
            not_expired_nb_ff     <= not_lce_raw;
            loop_back_ff          <= nxt_loop_back;
            exit_fetch_ff         <= nxt_exit;
            flush_fetch_ff        <= nxt_flush;
            stack_pop_ff          <= nxt_pop;
            sticky_status_ff      <= nxt_sticky;
        end
    end

    // checks on the loop logic
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_arith_hit;
        ar_hit;
    endsequence

    sequence s_exit_once;
        exit_fetch_ff && flush_fetch_ff && stack_pop_ff ##1 !exit_fetch_ff;
    endsequence

    a_empty_read: assert property (stk_empty |=> current_loop_count_ff == `HLC_EMPTY_READ)
        else $error("empty stack read is not all ones");

    a_empty_write: assert property (cur_wr && stk_empty && !do_push |=> stk_empty)
        else $error("write to empty stack changed state");

    a_write_replace: assert property (cur_wr && ctr_run && !do_pop && !do_push
        |=> stk_top.count == $past(cur_wr_data) && !stk_empty)
        else $error("count write did not replace the top count");

    a_nonctr_write: assert property (cur_wr && !stk_empty && !ctr_run && !do_pop
        && !do_push |=> $stable(stk_top))
        else $error("count write changed a non-counter loop");

    a_init_hold: assert property (!init_wr |=> $stable(loop_count_init_ff))
        else $error("init count changed without a write");

    a_count_dec: assert property (end_fetch && ctr_run && !ctr_end && !cur_wr
        && !do_pop && !do_push |=> stk_top.count == $past(stk_top.count) - 1'b1)
        else $error("count did not decrement at end fetch");

    a_br_latency: assert property (not_lce_raw != $past(not_lce_raw)
        |-> ##2 not_expired_br_ff == $past(not_lce_raw, 2))
        else $error("branch expiry latency wrong");

    a_nb_latency: assert property (##1 not_expired_nb_ff == $past(not_lce_raw))
        else $error("non-branch expiry latency wrong");

    a_arith_exit: assert property (s_arith_hit |=> s_exit_once)
        else $error("condition loop exit sequence wrong");

    a_ovf_sticky: assert property (sticky_status_ff[`HLC_STKY_LOOP_STACK_OVERFLOW_FLAG] && !ovf_clr
        |=> sticky_status_ff[`HLC_STKY_LOOP_STACK_OVERFLOW_FLAG])
        else $error("overflow flag dropped without clear");

    a_empty_flag: assert property (stk_empty && !do_push
        |=> sticky_status_ff[`HLC_STKY_LOOP_STACK_EMPTY_FLAG])
        else $error("empty flag not set while empty");

    // loop entry and exit checks
    a_init_load: assert property (do_push && loop_start && !stk_full
        |=> stk_top.count == $past(loop_count_init_ff))
        else $error("loop start did not load the init count");

    a_count_pop: assert property (ctr_end |=> stack_pop_ff && !loop_back_ff)
        else $error("expired counter loop did not pop");

    a_zero_wrap: assert property (end_fetch && ctr_run && stk_top.count == '0 && !cur_wr
        && !do_pop && !do_push |=> stk_top.count == 32'hFFFF_FFFF)
        else $error("zero count did not wrap");

    a_arith_pop: assert property (ar_hit |=> stack_pop_ff && !loop_back_ff)
        else $error("condition exit did not pop or still looped back");

    a_single_test: assert property (state_ff == ST_RUN && !stk_empty
        && stk_top.kind == KIND_ARITH && stk_top.single && arith_cond
        |=> exit_fetch_ff)
        else $error("single loop missed its condition");

    a_forever_back: assert property (end_fetch && state_ff == ST_RUN && !stk_empty
        && stk_top.kind == KIND_FOREVER && !do_pop |=> loop_back_ff)
        else $error("endless loop did not loop back");

    // stack status checks
    a_ovf_set: assert property (do_push && stk_full
        |=> sticky_status_ff[`HLC_STKY_LOOP_STACK_OVERFLOW_FLAG])
        else $error("overflow flag not set on full push");

    a_full_keep: assert property (do_push && stk_full |=> stk_full)
        else $error("push while full changed depth");

    a_push_clears: assert property (do_push
        |=> !sticky_status_ff[`HLC_STKY_LOOP_STACK_EMPTY_FLAG])
        else $error("empty flag not cleared by push");

endmodule

// ===== hlc_pipe_model.sv
`timescale 1ns/1ps

module hlc_pipe_model import hlc_pkg::*; (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // loop run request from the bench
    input  wire logic       run,
    input  wire logic [3:0] body_len,
    // sequencer decision
    input  wire logic       stack_pop_ff,
    // fetch events
    output logic            end_fetch,
    output logic            second_fetch
);
    int   pos;
    logic active;

    initial begin
        pos          = 1;
        active       = 1'b0;
        end_fetch    = 1'b0;
        second_fetch = 1'b0;
    end

    // program fetch walk; changes right after the edge so the sequencer sees a full cycle
    // the program keeps a full-width tail, no branch, idle or stack traffic near the end
    always @(posedge clk_sys) begin
        end_fetch    <= 1'b0;
        second_fetch <= 1'b0;
        if (rst || stack_pop_ff) begin
            active <= 1'b0;
        end else if (run) begin
            active <= 1'b1;
            pos    <= 1;
        end else if (active) begin
            pos          <= (pos == int'(body_len)) ? 1 : pos + 1;
            end_fetch    <= (pos == int'(body_len));
            second_fetch <= (pos == 2);
        end
    end
endmodule

// ===== tb_hlc_loop_seq.sv
`timescale 1ns/1ps
`include "hlc_regs.svh"

module tb_hlc_loop_seq import hlc_pkg::*;;
    logic clk_sys = 1'b0, rst = 1'b1, run = 1'b0;
    logic loop_start = 1'b0, loop_start_single = 1'b0, end_fetch, second_fetch;
    logic push_loop_instr = 1'b0, pop_loop_instr = 1'b0, cur_wr = 1'b0, init_wr = 1'b0;
    logic arith_cond = 1'b0, mult_cond = 1'b0, stall = 1'b0, ovf_clr = 1'b0;
    logic [3:0]  body_len = 4'h0;
    logic [31:0] cur_wr_data = 32'h0000_0000, init_wr_data = 32'h0000_0000;
    hlc_kind_type loop_start_kind = KIND_COUNT;
    logic [31:0] current_loop_count_ff, loop_count_init_ff, sticky_status_ff;
    logic not_expired_br_ff, not_expired_nb_ff, loop_back_ff, exit_fetch_ff;
    logic flush_fetch_ff, stack_pop_ff;
    int   fail_count = 0, compares = 0, lb_n = 0, pop_n = 0, cycles = 0;

    // 10 MHz core clock
    always #50 clk_sys = ~clk_sys;

    hlc_loop_seq dut_u (.clk_sys, .rst, .loop_start, .loop_start_kind, .loop_start_single,
        .end_fetch, .second_fetch, .push_loop_instr, .pop_loop_instr, .cur_wr, .cur_wr_data,
        .init_wr, .init_wr_data, .arith_cond, .mult_cond, .stall, .ovf_clr,
        .current_loop_count_ff, .loop_count_init_ff, .not_expired_br_ff, .not_expired_nb_ff,
        .loop_back_ff, .exit_fetch_ff, .flush_fetch_ff, .stack_pop_ff, .sticky_status_ff);

    hlc_pipe_model pipe_u (.clk_sys, .rst, .run, .body_len, .stack_pop_ff, .end_fetch,
        .second_fetch);

    // loop decisions counted where outputs have settled
    always @(negedge clk_sys) begin
        lb_n  += (loop_back_ff === 1'b1);
        pop_n += (stack_pop_ff === 1'b1);
    end

    // hang guard, far above the under two hundred cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // reset also lands in mid-loop, which the design must survive
    task automatic do_reset();
        rst = 1'b1;
        cyc(6);
        rst  = 1'b0;
        lb_n  = 0;
        pop_n = 0;
    endtask

    // loop start; a non-zero length lets the pipeline model fetch the body
    task automatic start(input hlc_kind_type k, input logic single, input logic [3:0] len);
        loop_start = 1'b1;
        loop_start_kind = k;
        loop_start_single = single;
        body_len = len;
        run = (len != 4'h0);
        cyc(1);
        loop_start = 1'b0;
        run = 1'b0;
    endtask

    task automatic t_reset();
        do_reset();
        chk("rst_count", current_loop_count_ff, `HLC_EMPTY_READ);
        chk("rst_init", loop_count_init_ff, 32'h0000_0000);
        chk("rst_sticky", sticky_status_ff, `HLC_STKY_RST);
        chk("rst_nb", not_expired_nb_ff, 32'h0000_0001);
        chk("rst_br", not_expired_br_ff, 32'h0000_0001);
        $display("test reset done");
    endtask

    task automatic t_cur_write();
        logic [31:0] prv;
        do_reset();
        cur_wr = 1'b1;
        cur_wr_data = 32'h0000_0005;
        cyc(1);
        cur_wr = 1'b0;
        cyc(1);
        chk("empty_wr_count", current_loop_count_ff, `HLC_EMPTY_READ);
        chk("empty_wr_sticky", sticky_status_ff, `HLC_STKY_RST);
        init_wr = 1'b1;
        init_wr_data = 32'h0000_0009;
        cyc(1);
        init_wr = 1'b0;
        start(KIND_COUNT, 1'b0, 4'h0);
        cyc(1);
        chk("init_count", current_loop_count_ff, 32'h0000_0009);
        cur_wr = 1'b1;
        cyc(1);
        cur_wr = 1'b0;
        cyc(1);
        chk("wr_count", current_loop_count_ff, 32'h0000_0005);
        chk("init_kept", loop_count_init_ff, 32'h0000_0009);
        pop_loop_instr = 1'b1;
        cyc(1);
        pop_loop_instr = 1'b0;
        chk("one_pop_empty", sticky_status_ff, `HLC_STKY_RST);
        start(KIND_ARITH, 1'b0, 4'h0);
        cyc(1);
        prv = current_loop_count_ff;
        cur_wr = 1'b1;
        cur_wr_data = 32'h0000_0007;
        cyc(1);
        cur_wr = 1'b0;
        cyc(2);
        chk("arith_wr_count", current_loop_count_ff, prv);
        $display("test current count write done");
    endtask

    task automatic t_count();
        logic [31:0] prv;
        logic        br_next;
        do_reset();
        init_wr = 1'b1;
        init_wr_data = 32'h0000_0003;
        cyc(1);
        init_wr = 1'b0;
        start(KIND_COUNT, 1'b0, 4'h4);
        cyc(1);
        chk("cnt_start", current_loop_count_ff, 32'h0000_0003);
        prv = current_loop_count_ff;
        br_next = 1'b0;
        repeat (30) begin
            cyc(1);
            if (br_next)
                chk("br_late", not_expired_br_ff, 32'h0000_0000);
            br_next = 1'b0;
            if (current_loop_count_ff === `HLC_CNT_LAST && prv !== `HLC_CNT_LAST) begin
                chk("nb_one", not_expired_nb_ff, 32'h0000_0000);
                chk("br_two", not_expired_br_ff, 32'h0000_0001);
                br_next = 1'b1;
            end
            prv = current_loop_count_ff;
        end
        chk("loop_backs", lb_n, 32'h0000_0002);
        chk("pops", pop_n, 32'h0000_0001);
        chk("init_hold", loop_count_init_ff, 32'h0000_0003);
        chk("done_count", current_loop_count_ff, `HLC_EMPTY_READ);
        $display("test counter loop done");
    endtask

    task automatic t_zero();
        int n;
        do_reset();
        start(KIND_COUNT, 1'b0, 4'h3);
        n = 0;
        while (lb_n == 0 && n < 20) begin
            cyc(1);
            n++;
        end
        cyc(1);
        chk("zero_wrap", current_loop_count_ff, 32'hFFFF_FFFF);
        chk("zero_not_empty", sticky_status_ff[`HLC_STKY_LOOP_STACK_EMPTY_FLAG], 32'h0000_0000);
        chk("zero_no_pop", pop_n, 32'h0000_0000);
        $display("test zero count done");
    endtask

    task automatic t_arith();
        do_reset();
        start(KIND_ARITH, 1'b0, 4'h4);
        cyc(4);
        arith_cond = 1'b1;
        cyc(2);
        chk("false_no_exit", exit_fetch_ff, 32'h0000_0000);
        chk("false_loop_back", lb_n, 32'h0000_0001);
        cyc(1);
        chk("exit", exit_fetch_ff, 32'h0000_0001);
        chk("flush", flush_fetch_ff, 32'h0000_0001);
        chk("exit_pop", stack_pop_ff, 32'h0000_0001);
        chk("exit_no_lb", loop_back_ff, 32'h0000_0000);
        arith_cond = 1'b0;
        $display("test arithmetic loop done");
    endtask

    // single-instruction loop: plain condition, late multiplier status, stalled status
    task automatic t_single();
        logic a_tab [3] = '{1'b1, 1'b0, 1'b0};
        logic s_tab [3] = '{1'b0, 1'b0, 1'b1};
        int   d_tab [3] = '{1, 2, 1};
        for (int i = 0; i < 3; i++) begin
            do_reset();
            start(KIND_ARITH, 1'b1, 4'h0);
            cyc(1);
            arith_cond = a_tab[i];
            mult_cond = ~a_tab[i];
            stall = s_tab[i];
            cyc(1);
            chk("single_exit_1", exit_fetch_ff, 32'(d_tab[i] == 1));
            cyc(1);
            chk("single_exit_2", exit_fetch_ff, 32'(d_tab[i] == 2));
            arith_cond = 1'b0;
            mult_cond = 1'b0;
            stall = 1'b0;
        end
        $display("test single loop done");
    endtask

    task automatic t_forever();
        do_reset();
        start(KIND_FOREVER, 1'b0, 4'h2);
        cyc(20);
        chk("forever_backs", 32'(lb_n > 5), 32'h0000_0001);
        chk("forever_no_pop", pop_n, 32'h0000_0000);
        $display("test endless loop done");
    endtask

    task automatic t_overflow();
        do_reset();
        push_loop_instr = 1'b1;
        cyc(7);
        push_loop_instr = 1'b0;
        cyc(4);
        chk("ovf_sticky", sticky_status_ff[`HLC_STKY_LOOP_STACK_OVERFLOW_FLAG], 32'h0000_0001);
        ovf_clr = 1'b1;
        cyc(1);
        ovf_clr = 1'b0;
        chk("ovf_clr", sticky_status_ff, 32'h0000_0000);
        pop_loop_instr = 1'b1;
        cyc(5);
        chk("five_pops", sticky_status_ff, 32'h0000_0000);
        cyc(1);
        pop_loop_instr = 1'b0;
        chk("six_pops", sticky_status_ff, `HLC_STKY_RST);
        $display("test stack depth done");
    endtask

    initial begin
        t_reset();
        t_cur_write();
        t_count();
        t_zero();
        t_arith();
        t_single();
        t_forever();
        t_overflow();
        end_of_test();
    end
endmodule
